// >>> include/bdcc_defines.svh
// Offsets, field positions, reset values and timing counts for the backup domain clock control block
//
// Function
// [RULE_01] Oscillator enable, bypass, source select and gate change only while backup write unlocked.
// [RULE_02] Control register resets to 0x18 only by backup-domain reset, not system reset.
// [RULE_03] Word, halfword and byte access; zero to three waits, more when back to back.
// [RULE_04] Bit 0 starts the slow external oscillator when 1, stops it when 0.
// [RULE_05] Read-only bit 1 is high exactly while the slow external clock is stable.
// [RULE_06] Bit 2 selects bypass of an external clock (1) or crystal resonator (0).
// [RULE_07] Bits 4:3 set crystal drive: weak, medium-low, medium-high, strong.
// [RULE_08] Drive strength returns to its default on every backup-domain reset.
// [RULE_09] Bits 9:8 pick realtime clock source; bit 15 gates that clock on.
// [RULE_10] Source select cannot be rewritten once set; a domain reset must come first.
// [RULE_11] Bit 16 holds the backup domain in reset until software clears it.
// [RULE_12] Soft reset affects only the oscillator, realtime clock selection and gate, this register.
// [RULE_13] Reserved bits 7:5, 14:10 and 31:17 read zero and ignore writes.
`ifndef BDCC_DEFINES_SVH
`define BDCC_DEFINES_SVH

`define BDCC_OFF_CTRL 8'h20
`define BDCC_OFF_IRQ_STATUS 8'h40
`define BDCC_OFF_IRQ_CLEAR 8'h44
`define BDCC_OFF_IRQ_ENABLE 8'h48

`define BDCC_CTRL_RESET 32'h0000_0018
`define BDCC_DRIVE_RESET 2'h3

`define BDCC_BIT_OSC_ON 0
`define BDCC_BIT_READY 1
`define BDCC_BIT_BYPASS 2
`define BDCC_DRIVE_LO 3
`define BDCC_DRIVE_HI 4
`define BDCC_SRC_LO 8
`define BDCC_SRC_HI 9
`define BDCC_BIT_GATE 15
`define BDCC_BIT_SOFT_RST 16

`define BDCC_IRQ_READY_ROSE 0
`define BDCC_IRQ_READY_FELL 1
`define BDCC_IRQ_BITS 2

`define BDCC_WAIT_MAX 3

`endif

// >>> include/bdcc_pkg.sv
// Types shared by the backup domain clock control block
`default_nettype none
package bdcc_pkg;
    typedef enum logic [1:0] {
        BDCC_SRC_NONE = 2'b00,
        BDCC_SRC_SLOW_EXT = 2'b01,
        BDCC_SRC_SLOW_INT = 2'b10,
        BDCC_SRC_FAST_DIV32 = 2'b11
    } bdcc_src_t;

    typedef enum logic [1:0] {
        BDCC_DRV_WEAK = 2'b00,
        BDCC_DRV_MED_LOW = 2'b01,
        BDCC_DRV_MED_HIGH = 2'b10,
        BDCC_DRV_STRONG = 2'b11
    } bdcc_drive_t;

    typedef enum logic {
        BDCC_BUS_IDLE = 1'b0,
        BDCC_BUS_DATA = 1'b1
    } bdcc_bus_state_t;
endpackage : bdcc_pkg
`default_nettype wire

// >>> hw/bdcc_sync3.sv
// Three-stage synchroniser with agreement filter for the oscillator stable pin
`timescale 1ns/1ns
`default_nettype none
module bdcc_sync3 (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Asynchronous level in, filtered level out
    input wire logic async_in,
    output logic level_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change accepted only once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_out <= s3_q;
        end
    end
endmodule : bdcc_sync3
`default_nettype wire

// >>> hw/bdcc_wait.sv
// Wait-state generator: back-to-back accesses add waits up to a ceiling
`timescale 1ns/1ns
`default_nettype none
`include "bdcc_defines.svh"
module bdcc_wait #(
    parameter int WAIT_MAX = `BDCC_WAIT_MAX
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Access taken, and whether a data phase is under way in the same cycle
    input wire logic accept,
    input wire logic in_data,
    // Bus ready out
    output logic ready
);
    logic [1:0] streak_q;
    logic [1:0] streak_d;
    logic [1:0] cnt_q;

    always_comb begin
        streak_d = 2'h0;
        if (accept && in_data) begin
            streak_d = (streak_q == 2'(WAIT_MAX)) ? streak_q : streak_q + 2'h1;
        end else if (!accept && !in_data) begin
            streak_d = 2'h0;
        end else begin
            streak_d = streak_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            streak_q <= 2'h0;
        end else if (accept || !in_data) begin
            streak_q <= streak_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 2'h0;
        end else if (accept) begin
            cnt_q <= streak_d;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end

    assign ready = (cnt_q == 2'h0);
endmodule : bdcc_wait
`default_nettype wire

// >>> hw/bdcc_top.sv
// Backup domain clock control: AHB-Lite register, oscillator and realtime clock controls, interrupts
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "bdcc_defines.svh"
module bdcc_top (
    // Clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic bd_reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Power unit unlock, same clock
    input wire logic backup_write_unlock,
    // Oscillator stable pin, asynchronous
    input wire logic slow_ext_stable_pin,
    // Controls to the oscillator and realtime clock
    output logic slow_ext_osc_on,
    output logic slow_ext_bypass_select,
    output logic [1:0] slow_ext_drive_strength,
    output logic [1:0] realtime_clock_source_select,
    output logic realtime_clock_gate,
    output logic backup_domain_soft_reset,
    // Interrupt
    output logic irq
);
    localparam logic [31:0] CTRL_KEEP = 32'h0001_831f;

    bdcc_pkg::bdcc_bus_state_t state_q;
    logic accept;
    logic [7:0] addr_q;
    logic write_q;
    logic [2:0] size_q;
    logic commit;
    logic [3:0] be;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] merged;
    // Lane-merged words for the interrupt clear and enable writes
    logic [31:0] clear_word;
    logic [31:0] enable_word;
    logic stable_sync;
    logic ready_q;
    logic [`BDCC_IRQ_BITS-1:0] irq_status_q;
    logic [`BDCC_IRQ_BITS-1:0] irq_enable_q;
    logic [`BDCC_IRQ_BITS-1:0] irq_event;
    logic [`BDCC_IRQ_BITS-1:0] irq_clear;

    // Byte lanes from size and low address bits
    function automatic logic [3:0] lanes(input logic [2:0] size, input logic [1:0] a);
        logic [3:0] m;
        m = 4'h0;
        case (size)
            3'h0: m = 4'h1 << a;
            3'h1: m = a[1] ? 4'hc : 4'h3;
            default: m = 4'hf;
        endcase
        return m;
    endfunction : lanes

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] m);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Bus front end
    assign accept = hsel && htrans[1] && hready;
    assign commit = (state_q == bdcc_pkg::BDCC_BUS_DATA) && write_q && hreadyout;
    assign be = lanes(size_q, addr_q[1:0]);
    assign hresp = 1'b0;

    // [RULE_03] Waits per access
    bdcc_wait #(
        .WAIT_MAX(`BDCC_WAIT_MAX)
    ) u_wait (
        .hclk(hclk),
        .hresetn(hresetn),
        .accept(accept),
        .in_data(state_q == bdcc_pkg::BDCC_BUS_DATA),
        .ready(hreadyout)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= bdcc_pkg::BDCC_BUS_IDLE;
        end else begin
            case (state_q)
                bdcc_pkg::BDCC_BUS_IDLE: begin
                    if (accept) begin
                        state_q <= bdcc_pkg::BDCC_BUS_DATA;
                    end
                end
                bdcc_pkg::BDCC_BUS_DATA: begin
                    if (hreadyout && !accept) begin
                        state_q <= bdcc_pkg::BDCC_BUS_IDLE;
                    end
                end
                default: state_q <= bdcc_pkg::BDCC_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            write_q <= 1'b0;
            size_q <= 3'h0;
        end else if (accept) begin
            addr_q <= haddr[7:0];
            write_q <= hwrite;
            size_q <= hsize;
        end
    end

    // Oscillator stable pin comes from the crystal, not our clock
    bdcc_sync3 u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(slow_ext_stable_pin),
        .level_out(stable_sync)
    );

    // [RULE_05] Ready follows the filtered stable level while the oscillator is on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= stable_sync && ctrl_q[`BDCC_BIT_OSC_ON];
        end
    end

    // Control register next value
    always_comb begin
        merged = merge(ctrl_q, hwdata, be);
        ctrl_d = ctrl_q;
        if (commit && addr_q[7:2] == `BDCC_OFF_CTRL >> 2) begin
            // [RULE_01] Protected fields need unlock
            if (backup_write_unlock) begin
                // [RULE_04] Oscillator on/off
                ctrl_d[`BDCC_BIT_OSC_ON] = merged[`BDCC_BIT_OSC_ON];
                // [RULE_06] Bypass or crystal
                ctrl_d[`BDCC_BIT_BYPASS] = merged[`BDCC_BIT_BYPASS];
                // [RULE_09] Realtime clock gate
                ctrl_d[`BDCC_BIT_GATE] = merged[`BDCC_BIT_GATE];
                // [RULE_10] Source locks once chosen
                if (ctrl_q[`BDCC_SRC_HI:`BDCC_SRC_LO] == bdcc_pkg::BDCC_SRC_NONE) begin
                    ctrl_d[`BDCC_SRC_HI:`BDCC_SRC_LO] = merged[`BDCC_SRC_HI:`BDCC_SRC_LO];
                end
            end
            // [RULE_07] Drive strength, not write protected
            ctrl_d[`BDCC_DRIVE_HI:`BDCC_DRIVE_LO] = merged[`BDCC_DRIVE_HI:`BDCC_DRIVE_LO];
            // [RULE_11] Soft reset bit set and cleared by software
            ctrl_d[`BDCC_BIT_SOFT_RST] = merged[`BDCC_BIT_SOFT_RST];
        end
        // [RULE_12] Soft reset clears only the domain fields, keeps itself
        if (ctrl_d[`BDCC_BIT_SOFT_RST]) begin
            // [RULE_08] Drive back to default
            ctrl_d = `BDCC_CTRL_RESET | (32'h1 << `BDCC_BIT_SOFT_RST);
        end
        // [RULE_13] Reserved and read-only bits never stored
        ctrl_d = ctrl_d & CTRL_KEEP & ~(32'h1 << `BDCC_BIT_READY);
    end

    // [RULE_02] Only the backup-domain reset touches this register
    always_ff @(posedge hclk or negedge bd_reset_n) begin
        if (!bd_reset_n) begin
            ctrl_q <= `BDCC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign slow_ext_osc_on = ctrl_q[`BDCC_BIT_OSC_ON];
    assign slow_ext_bypass_select = ctrl_q[`BDCC_BIT_BYPASS];
    assign slow_ext_drive_strength = ctrl_q[`BDCC_DRIVE_HI:`BDCC_DRIVE_LO];
    assign realtime_clock_source_select = ctrl_q[`BDCC_SRC_HI:`BDCC_SRC_LO];
    assign realtime_clock_gate = ctrl_q[`BDCC_BIT_GATE];
    assign backup_domain_soft_reset = ctrl_q[`BDCC_BIT_SOFT_RST];

    // Interrupt events from ready edges
    assign irq_event[`BDCC_IRQ_READY_ROSE] = stable_sync && ctrl_q[`BDCC_BIT_OSC_ON] && !ready_q;
    assign irq_event[`BDCC_IRQ_READY_FELL] = !(stable_sync && ctrl_q[`BDCC_BIT_OSC_ON]) && ready_q;
    assign clear_word = merge(32'h0, hwdata, be);
    assign enable_word = merge({30'h0, irq_enable_q}, hwdata, be);
    assign irq_clear = (commit && addr_q[7:2] == `BDCC_OFF_IRQ_CLEAR >> 2) ?
        clear_word[`BDCC_IRQ_BITS-1:0] : '0;

    // Set beats clear in the same cycle so no edge is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable_q <= '0;
        end else if (commit && addr_q[7:2] == `BDCC_OFF_IRQ_ENABLE >> 2) begin
            irq_enable_q <= enable_word[`BDCC_IRQ_BITS-1:0];
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // Read data captured at the address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            case (haddr[7:2])
                `BDCC_OFF_CTRL >> 2: hrdata <= ctrl_q | (32'(ready_q) << `BDCC_BIT_READY);
                `BDCC_OFF_IRQ_STATUS >> 2: hrdata <= {30'h0, irq_status_q};
                `BDCC_OFF_IRQ_ENABLE >> 2: hrdata <= {30'h0, irq_enable_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    chk_unlock_gate: assert property ( // [RULE_01]
        @(posedge hclk) disable iff (!bd_reset_n || !hresetn)
        (commit && !backup_write_unlock && !ctrl_d[`BDCC_BIT_SOFT_RST])
        |=> $stable(slow_ext_osc_on) && $stable(realtime_clock_gate) && $stable(slow_ext_bypass_select)
    ) else $error("protected field changed while locked");

    chk_sysreset_keep: assert property ( // [RULE_02]
        @(posedge hclk) disable iff (!bd_reset_n)
        !hresetn && !backup_domain_soft_reset |=> $stable(ctrl_q)
    ) else $error("control register changed under system reset");

    chk_wait_bound: assert property ( // [RULE_03]
        @(posedge hclk) disable iff (!hresetn)
        $fell(hreadyout) |-> ##[1:3] hreadyout
    ) else $error("more than three wait cycles");

    chk_osc_write: assert property ( // [RULE_04]
        @(posedge hclk) disable iff (!bd_reset_n || !hresetn)
        commit && backup_write_unlock && be[0] && addr_q[7:2] == `BDCC_OFF_CTRL >> 2
            && !ctrl_d[`BDCC_BIT_SOFT_RST]
        |=> slow_ext_osc_on == $past(hwdata[0])
    ) else $error("oscillator enable did not take written value");

    chk_ready_off: assert property ( // [RULE_05]
        @(posedge hclk) disable iff (!hresetn || !bd_reset_n)
        !slow_ext_osc_on ##1 !slow_ext_osc_on |-> !ready_q
    ) else $error("ready high with oscillator off");

    chk_src_lock: assert property ( // [RULE_10]
        @(posedge hclk) disable iff (!bd_reset_n)
        realtime_clock_source_select != 2'h0 && !ctrl_d[`BDCC_BIT_SOFT_RST] |=> $stable(realtime_clock_source_select)
    ) else $error("source select changed without domain reset");

    chk_soft_reset: assert property ( // [RULE_11]
        @(posedge hclk) disable iff (!bd_reset_n)
        backup_domain_soft_reset |-> !slow_ext_osc_on && !realtime_clock_gate
            && realtime_clock_source_select == 2'h0 && !slow_ext_bypass_select
    ) else $error("domain fields not held in reset");

    chk_drive_default: assert property ( // [RULE_08]
        @(posedge hclk) disable iff (!bd_reset_n)
        $rose(backup_domain_soft_reset) |-> slow_ext_drive_strength == `BDCC_DRIVE_RESET
    ) else $error("drive strength not restored");

    chk_reserved_zero: assert property ( // [RULE_13]
        @(posedge hclk) disable iff (!bd_reset_n || !hresetn)
        commit |=> (ctrl_q & ~CTRL_KEEP) == 32'h0
    ) else $error("reserved bits stored");
endmodule : bdcc_top
`default_nettype wire

// >>> tb/bdcc_top_tb.sv
// Self-checking bench for the backup domain clock control block
`timescale 1ns/1ns
`default_nettype none
`include "bdcc_defines.svh"
module bdcc_top_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic bd_reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic backup_write_unlock = 1'b0;
    logic slow_ext_stable_pin = 1'b0;
    logic slow_ext_osc_on;
    logic slow_ext_bypass_select;
    logic [1:0] slow_ext_drive_strength;
    logic [1:0] realtime_clock_source_select;
    logic realtime_clock_gate;
    logic backup_domain_soft_reset;
    logic irq;
    int mismatches = 0;
    int check_count = 0;
    integer seed = 32'hf482a1ab;

    always #4 hclk = ~hclk;

    bdcc_top dut (
        .hclk(hclk), .hresetn(hresetn), .bd_reset_n(bd_reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .backup_write_unlock(backup_write_unlock), .slow_ext_stable_pin(slow_ext_stable_pin),
        .slow_ext_osc_on(slow_ext_osc_on), .slow_ext_bypass_select(slow_ext_bypass_select),
        .slow_ext_drive_strength(slow_ext_drive_strength),
        .realtime_clock_source_select(realtime_clock_source_select),
        .realtime_clock_gate(realtime_clock_gate), .backup_domain_soft_reset(backup_domain_soft_reset),
        .irq(irq)
    );

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Samples ready mid-cycle so the value seen is the one the next edge takes
    task automatic wait_ready(output int waits);
        waits = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && waits < 100) begin
            waits++;
            @(negedge hclk);
        end
        if (waits >= 100) begin
            mismatches++;
            finish_test();
        end
    endtask : wait_ready

    // Entered just after a rising edge, leaves just after one
    task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= sz;
        wait_ready(n);
        @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready(n);
        rd = hrdata;
        @(posedge hclk);
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, 3'h2, d, r);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 3'h2, 32'h0, r);
        check(r, e);
    endtask : rdchk

    task automatic check_outs(input logic [31:0] c);
        check({24'h0, backup_domain_soft_reset, realtime_clock_gate, realtime_clock_source_select,
               slow_ext_drive_strength, slow_ext_bypass_select, slow_ext_osc_on},
              {24'h0, c[16], c[15], c[9:8], c[4:3], c[2], c[0]});
    endtask : check_outs

    task automatic chk_irq(input logic e);
        @(negedge hclk);
        check({31'h0, irq}, {31'h0, e});
        @(posedge hclk);
    endtask : chk_irq

    task automatic bd_pulse();
        bd_reset_n <= 1'b0;
        repeat (2) @(posedge hclk);
        bd_reset_n <= 1'b1;
        @(posedge hclk);
    endtask : bd_pulse

    // Pipelined reads of the control word; waits must stay capped
    task automatic burst(input int cnt, input logic [31:0] exp);
        int w;
        int tot;
        tot = 0;
        hsel <= 1'b1;
        haddr <= 32'h0000_0020;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        for (int i = 0; i <= cnt; i++) begin
            wait_ready(w);
            if (i > 0)
                check(hrdata, exp);
            check({31'h0, w <= `BDCC_WAIT_MAX}, 32'h1);
            tot += w;
            @(posedge hclk);
            if (i == cnt - 1) begin
                htrans <= 2'h0;
                hsel <= 1'b0;
            end
        end
        check({31'h0, tot > 0}, 32'h1);
    endtask : burst

    // Expected control word after a full-word write, ready bit left out
    function automatic logic [31:0] ctrl_model(input logic [31:0] old, input logic [31:0] w, input logic unl);
        logic [31:0] n;
        n = old;
        n[4:3] = w[4:3];
        n[16] = w[16];
        if (unl) begin
            n[0] = w[0];
            n[2] = w[2];
            n[15] = w[15];
            if (old[9:8] == 2'b00)
                n[9:8] = w[9:8];
        end
        if (n[16])
            n = 32'h0001_0018;
        return n & 32'h0001_831d;
    endfunction : ctrl_model

    initial begin
        #(8 * 20000);
        mismatches++;
        finish_test();
    end

    initial begin
        logic [31:0] e;
        logic [31:0] w;
        logic [31:0] r;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        bd_reset_n <= 1'b1;
        @(posedge hclk);
        rdchk(`BDCC_OFF_CTRL, `BDCC_CTRL_RESET);
        check_outs(`BDCC_CTRL_RESET);
        // locked and unlocked writes, every source code
        for (int i = 0; i < 8; i++) begin
            bd_pulse();
            w = $random(seed);
            w[9:8] = i[1:0];
            w[16] = 1'b0;
            backup_write_unlock <= i[2];
            wr(`BDCC_OFF_CTRL, w);
            e = ctrl_model(`BDCC_CTRL_RESET, w, i[2]);
            rdchk(`BDCC_OFF_CTRL, e);
            check_outs(e);
            w = $random(seed);
            w[16] = 1'b0;
            backup_write_unlock <= 1'b1;
            wr(`BDCC_OFF_CTRL, w);
            e = ctrl_model(e, w, 1'b1);
            rdchk(`BDCC_OFF_CTRL, e);
        end
        // system reset keeps the control word
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(`BDCC_OFF_CTRL, e);
        bd_pulse();
        rdchk(`BDCC_OFF_CTRL, `BDCC_CTRL_RESET);
        // narrow lanes, then soft reset by halfword
        wr(`BDCC_OFF_IRQ_ENABLE, 32'h2);
        xfer(32'h21, 1'b1, 3'h0, 32'h0000_8100, r);
        rdchk(`BDCC_OFF_CTRL, 32'h0000_8118);
        xfer(32'h20, 1'b1, 3'h1, 32'h0000_0005, r);
        rdchk(`BDCC_OFF_CTRL, 32'h0000_0105);
        xfer(32'h22, 1'b1, 3'h1, 32'h0001_0000, r);
        rdchk(`BDCC_OFF_CTRL, 32'h0001_0018);
        check_outs(32'h0001_0018);
        wr(`BDCC_OFF_CTRL, 32'h0001_8207);
        rdchk(`BDCC_OFF_CTRL, 32'h0001_0018);
        rdchk(`BDCC_OFF_IRQ_ENABLE, 32'h2);
        wr(`BDCC_OFF_CTRL, 32'h18);
        wr(`BDCC_OFF_CTRL, 32'h0200);
        rdchk(`BDCC_OFF_CTRL, 32'h0200);
        burst(4, 32'h0200);
        // Unmapped place reads zero
        w = $random(seed);
        wr(32'h84, w);
        rdchk(32'h84, 32'h0);
        rdchk(`BDCC_OFF_CTRL, 32'h0200);
        // ready follows the stable pin, events latch
        wr(`BDCC_OFF_CTRL, 32'h1);
        wr(`BDCC_OFF_IRQ_ENABLE, 32'h3);
        slow_ext_stable_pin <= 1'b1;
        repeat (10) @(posedge hclk);
        rdchk(`BDCC_OFF_CTRL, 32'h0203);
        rdchk(`BDCC_OFF_IRQ_STATUS, 32'h1);
        chk_irq(1'b1);
        wr(`BDCC_OFF_IRQ_CLEAR, 32'h1);
        rdchk(`BDCC_OFF_IRQ_STATUS, 32'h0);
        chk_irq(1'b0);
        wr(`BDCC_OFF_IRQ_ENABLE, 32'h0);
        slow_ext_stable_pin <= 1'b0;
        repeat (10) @(posedge hclk);
        rdchk(`BDCC_OFF_CTRL, 32'h0201);
        rdchk(`BDCC_OFF_IRQ_STATUS, 32'h2);
        chk_irq(1'b0);
        wr(`BDCC_OFF_IRQ_ENABLE, 32'h2);
        chk_irq(1'b1);
        rdchk(`BDCC_OFF_IRQ_CLEAR, 32'h0);
        wr(`BDCC_OFF_IRQ_CLEAR, 32'h2);
        chk_irq(1'b0);
        check({31'h0, hresp}, 32'h0);
        finish_test();
    end
endmodule : bdcc_top_tb
`default_nettype wire
